// ==== src/hsc_pkg.sv ====
// constants and types shared by the heater startup and calibration sequencer
package hsc_pkg;

	// --------------------------------------------------------------------
	// clock and timing
	// --------------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned POWERUP_MS = 300;
	localparam int unsigned SLOW_BLINK_HZ = 1;
	localparam int unsigned FAST_BLINK_HZ = 4;
	localparam int unsigned CAL_RUN_S = 12;
	localparam int unsigned LINE_MIN_HZ = 47;
	localparam int unsigned LINE_MAX_HZ = 63;
	localparam int unsigned POWERUP_CYC = CLK_HZ / 1000 * POWERUP_MS;
	localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
	localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
	localparam int unsigned CAL_RUN_CYC = CLK_HZ * CAL_RUN_S;
	// shortest line period belongs to the highest frequency, rounded up
	localparam int unsigned LINE_MIN_CYC = (CLK_HZ + LINE_MAX_HZ - 1) / LINE_MAX_HZ;
	localparam int unsigned LINE_MAX_CYC = CLK_HZ / LINE_MIN_HZ;

	// --------------------------------------------------------------------
	// register map, byte addresses
	// --------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_LINE_PERIOD = 8'h10;
	localparam logic [7:0] ADDR_SETPOINT = 8'h14;

	// control bits
	localparam int CTRL_CAL_REQ = 0;
	localparam int CTRL_START_HEAT = 1;
	localparam int CTRL_CAL_EN = 2;
	localparam int CTRL_HEAT_EN = 3;
	localparam logic [3:0] CTRL_RESET = 4'hc;
	// status bits
	localparam int STAT_CAL_ACTIVE = 0;
	localparam int STAT_ALARM_ACTIVE = 1;
	localparam int STAT_CTRL_ACTIVE = 2;
	localparam int STAT_LINE_OK = 3;
	localparam int STAT_CFG_CHANGED = 4;
	localparam int STAT_CAL_GOOD = 5;
	// interrupt events
	localparam int IRQ_CAL_DONE = 0;
	localparam int IRQ_CAL_FAIL = 1;
	localparam int IRQ_LINK_UP = 2;
	localparam int IRQ_LINE_LOST = 3;
	localparam int IRQ_W = 4;

	// --------------------------------------------------------------------
	// analog output codes, 12 bit over 0..10 v
	// --------------------------------------------------------------------
	localparam int DAC_W = 12;
	localparam logic [11:0] DAC_ZERO = 12'h000;
	localparam logic [11:0] DAC_CAL_300 = 12'h10e;
	localparam logic [11:0] DAC_CAL_500 = 12'h0a4;
	localparam int SETPOINT_W = 16;

	// --------------------------------------------------------------------
	// types
	// --------------------------------------------------------------------
	typedef enum logic [3:0] {
		HSC_POWERUP = 4'b0001,
		HSC_IDLE = 4'b0010,
		HSC_CAL = 4'b0100,
		HSC_HEAT = 4'b1000
	} hsc_state_e;

	typedef struct packed {
		logic cal;
		logic alarm;
		logic heat;
		logic link;
	} hsc_led_s;

endpackage

// ==== src/hsc_sequencer.sv ====
// heater startup, zero calibration and heat sequencing with wishbone registers
`timescale 1ns/1ns

// How it works
// R1: calibration light on 0.3 s after power-up
// R2: blink calibration light 1 Hz without link
// R3: altered configuration adds 0.3 s alarm light
// R4: link light follows active link_active_indicator
// R5: calibration request runs calibration, light lit
// R6: calibration raises active bit, output zero volts
// R7: success clears light, drives range zero code
// R8: failure raises alarm bit, alarm blinks 1 Hz
// R9: start bit raises controller active, heat light
// R10: master keeps start bit clear at power-up
// R11: master calibrates cold band after replacement
// R12: master heats only after good calibration
// R13: master recalibrates after band burn-in
// R14: line frequency 47 to 63 Hz detected
// R15: disabled calibration request blinks light 4 Hz
// R16: disabled heat request blinks heat light fast
// R17: no heating while calibration runs
module hsc_sequencer #(
	parameter int unsigned POWERUP_CYC = hsc_pkg::POWERUP_CYC,
	parameter int unsigned SLOW_HALF_CYC = hsc_pkg::SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF_CYC = hsc_pkg::FAST_HALF_CYC,
	parameter int unsigned CAL_RUN_CYC = hsc_pkg::CAL_RUN_CYC,
	parameter int unsigned LINE_MIN_CYC = hsc_pkg::LINE_MIN_CYC,
	parameter int unsigned LINE_MAX_CYC = hsc_pkg::LINE_MAX_CYC
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// plant side
	input wire logic link_active_i,
	input wire logic config_changed_i,
	input wire logic line_sync_i,
	input wire logic zero_ok_i,
	input wire logic range_500_i,
	input wire logic [11:0] actual_value_i,
	// indicators and outputs
	output hsc_pkg::hsc_led_s leds_o,
	output logic heat_on_o,
	output logic [11:0] actual_dac_o,
	output logic irq_o
);

	// --------------------------------------------------------------------
	// state
	// --------------------------------------------------------------------
	hsc_pkg::hsc_state_e state;
	logic [3:0] ctrl;
	logic [hsc_pkg::SETPOINT_W-1:0] setpoint;
	logic [hsc_pkg::IRQ_W-1:0] irq_stat;
	logic [hsc_pkg::IRQ_W-1:0] irq_mask;
	logic [31:0] timer;
	logic [31:0] slow_cnt;
	logic [31:0] fast_cnt;
	logic slow_blink;
	logic fast_blink;
	logic cfg_changed;
	logic cfg_taken;
	logic cal_armed;
	logic cal_good;
	logic alarm_active;
	logic [31:0] line_cnt;
	logic [31:0] line_period;
	logic line_ok;
	logic sync_q;
	logic link_q;
	logic wb_req;
	logic cal_start;
	logic cal_end;
	logic line_edge;
	logic [hsc_pkg::IRQ_W-1:0] irq_event;

	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat,
			input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [31:0] count_down(input logic [31:0] cnt, input int unsigned reload);
		return (cnt == 32'h0) ? 32'(reload - 1) : cnt - 32'h1;
	endfunction

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cal_start = (state == hsc_pkg::HSC_IDLE) && ctrl[hsc_pkg::CTRL_CAL_REQ]
		&& ctrl[hsc_pkg::CTRL_CAL_EN] && cal_armed;
	assign cal_end = (state == hsc_pkg::HSC_CAL) && (timer == 32'h0);
	assign line_edge = line_sync_i && !sync_q;

	// --------------------------------------------------------------------
	// wishbone slave: ack one cycle after the request, unmapped reads zero
	// --------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					hsc_pkg::ADDR_CTRL: wb_dat_o <= {setpoint, 12'h0, ctrl};
					hsc_pkg::ADDR_STATUS: wb_dat_o <= {26'h0, cal_good, cfg_changed, line_ok,
						state == hsc_pkg::HSC_HEAT, alarm_active, state == hsc_pkg::HSC_CAL};
					hsc_pkg::ADDR_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat};
					hsc_pkg::ADDR_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask};
					hsc_pkg::ADDR_LINE_PERIOD: wb_dat_o <= line_period;
					hsc_pkg::ADDR_SETPOINT: wb_dat_o <= {16'h0, setpoint};
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// control, setpoint and mask registers
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl <= hsc_pkg::CTRL_RESET;
			setpoint <= '0;
			irq_mask <= '0;
		end else if (wb_req && wb_we_i) begin
			if (wb_adr_i == hsc_pkg::ADDR_CTRL) begin
				ctrl <= 4'(wb_merge({28'h0, ctrl}, wb_dat_i, wb_sel_i));
			end
			if (wb_adr_i == hsc_pkg::ADDR_SETPOINT) begin
				setpoint <= 16'(wb_merge({16'h0, setpoint}, wb_dat_i, wb_sel_i));
			end
			if (wb_adr_i == hsc_pkg::ADDR_IRQ_MASK) begin
				irq_mask <= 4'(wb_merge({28'h0, irq_mask}, wb_dat_i, wb_sel_i));
			end
		end
	end

	// --------------------------------------------------------------------
	// interrupts: sticky, write one to clear, a new event wins over the clear
	// --------------------------------------------------------------------
	assign irq_event[hsc_pkg::IRQ_CAL_DONE] = cal_end && zero_ok_i;
	assign irq_event[hsc_pkg::IRQ_CAL_FAIL] = cal_end && !zero_ok_i;
	assign irq_event[hsc_pkg::IRQ_LINK_UP] = link_active_i && !link_q;
	assign irq_event[hsc_pkg::IRQ_LINE_LOST] = line_ok
		&& (line_cnt >= 32'(LINE_MAX_CYC)) && !line_edge;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			irq_stat <= '0;
		end else if (wb_req && wb_we_i && wb_adr_i == hsc_pkg::ADDR_IRQ_STAT && wb_sel_i[0]) begin
			irq_stat <= (irq_stat & ~wb_dat_i[3:0]) | irq_event;
		end else begin
			irq_stat <= irq_stat | irq_event;
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// --------------------------------------------------------------------
	// blink sources, free running
	// --------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			slow_cnt <= 32'h0;
			fast_cnt <= 32'h0;
			slow_blink <= 1'b0;
			fast_blink <= 1'b0;
		end else begin
			slow_cnt <= count_down(slow_cnt, SLOW_HALF_CYC);
			fast_cnt <= count_down(fast_cnt, FAST_HALF_CYC);
			if (slow_cnt == 32'h0) begin
				slow_blink <= !slow_blink;
			end
			if (fast_cnt == 32'h0) begin
				fast_blink <= !fast_blink;
			end
		end
	end

	// the configuration strap is caught by the first clock after reset release
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cfg_taken <= 1'b0;
			cfg_changed <= 1'b0;
		end else if (!cfg_taken) begin
			cfg_taken <= 1'b1;
			cfg_changed <= config_changed_i;
		end
	end

	// --------------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state <= hsc_pkg::HSC_POWERUP;
			timer <= 32'(POWERUP_CYC - 1);
		end else begin
			unique case (state)
				hsc_pkg::HSC_POWERUP: begin
					timer <= timer - 32'h1;
					if (timer == 32'h0) begin
						state <= hsc_pkg::HSC_IDLE;
					end
				end
				hsc_pkg::HSC_IDLE: begin
					// R5: request starts a timed run
					if (cal_start) begin
						state <= hsc_pkg::HSC_CAL;
						timer <= 32'(CAL_RUN_CYC - 1);
					// R9: start bit with enable enters heating
					end else if (ctrl[hsc_pkg::CTRL_START_HEAT] && ctrl[hsc_pkg::CTRL_HEAT_EN]) begin
						state <= hsc_pkg::HSC_HEAT;
					end
				end
				// R17: start bit is not looked at until the run ends
				hsc_pkg::HSC_CAL: begin
					timer <= timer - 32'h1;
					if (timer == 32'h0) begin
						state <= hsc_pkg::HSC_IDLE;
					end
				end
				hsc_pkg::HSC_HEAT: begin
					if (!ctrl[hsc_pkg::CTRL_START_HEAT] || !ctrl[hsc_pkg::CTRL_HEAT_EN]) begin
						state <= hsc_pkg::HSC_IDLE;
					end
				end
			endcase
		end
	end

	// one run per request: the bit must drop before another run is taken
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cal_armed <= 1'b1;
			cal_good <= 1'b0;
			alarm_active <= 1'b0;
		end else begin
			if (cal_start) begin
				cal_armed <= 1'b0;
				alarm_active <= 1'b0;
				cal_good <= 1'b0;
			end else if (!ctrl[hsc_pkg::CTRL_CAL_REQ]) begin
				cal_armed <= 1'b1;
			end
			// R7 R8: result is sampled as the run ends
			if (cal_end) begin
				cal_good <= zero_ok_i;
				alarm_active <= !zero_ok_i;
			end
		end
	end

	// --------------------------------------------------------------------
	// line frequency: period between rising sync edges must sit in the window
	// --------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sync_q <= 1'b0;
			link_q <= 1'b0;
			line_cnt <= 32'h0;
			line_period <= 32'h0;
			line_ok <= 1'b0;
		end else begin
			sync_q <= line_sync_i;
			link_q <= link_active_i;
			// R14: accept any period within the window, no setting needed
			if (line_edge) begin
				line_cnt <= 32'h0;
				line_period <= line_cnt + 32'h1;
				line_ok <= (line_cnt + 32'h1 >= 32'(LINE_MIN_CYC))
					&& (line_cnt + 32'h1 <= 32'(LINE_MAX_CYC));
			end else if (line_cnt >= 32'(LINE_MAX_CYC)) begin
				line_ok <= 1'b0;
			end else begin
				line_cnt <= line_cnt + 32'h1;
			end
		end
	end

	// --------------------------------------------------------------------
	// indicators and analog output
	// --------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			leds_o <= '0;
			heat_on_o <= 1'b0;
			actual_dac_o <= hsc_pkg::DAC_ZERO;
		end else begin
			// R1 R5 R15 R2: calibration light, highest cause first
			if (state == hsc_pkg::HSC_POWERUP || state == hsc_pkg::HSC_CAL) begin
				leds_o.cal <= 1'b1;
			end else if (ctrl[hsc_pkg::CTRL_CAL_REQ] && !ctrl[hsc_pkg::CTRL_CAL_EN]) begin
				leds_o.cal <= fast_blink;
			end else if (!link_active_i) begin
				leds_o.cal <= slow_blink;
			end else begin
				leds_o.cal <= 1'b0;
			end
			// R3 R8: alarm light
			if (state == hsc_pkg::HSC_POWERUP) begin
				leds_o.alarm <= cfg_changed;
			end else begin
				leds_o.alarm <= alarm_active && slow_blink;
			end
			// R9 R16: heat light
			if (state == hsc_pkg::HSC_HEAT) begin
				leds_o.heat <= 1'b1;
			end else begin
				leds_o.heat <= ctrl[hsc_pkg::CTRL_START_HEAT] && !ctrl[hsc_pkg::CTRL_HEAT_EN]
					&& fast_blink;
			end
			// R4: link light
			leds_o.link <= link_active_i;
			heat_on_o <= state == hsc_pkg::HSC_HEAT;
			// R6 R7: zero during the run, range code after a good one while not heating
			if (state == hsc_pkg::HSC_CAL) begin
				actual_dac_o <= hsc_pkg::DAC_ZERO;
			end else if (state == hsc_pkg::HSC_HEAT || !cal_good) begin
				actual_dac_o <= actual_value_i;
			end else begin
				actual_dac_o <= range_500_i ? hsc_pkg::DAC_CAL_500 : hsc_pkg::DAC_CAL_300;
			end
		end
	end

	// --------------------------------------------------------------------
	// checks
	// --------------------------------------------------------------------
	chk_powerup_light: assert property (@(posedge clock_i) disable iff (reset_i) // R1
		state == hsc_pkg::HSC_POWERUP |=> leds_o.cal)
		else $error("calibration light dark during power-up");
	chk_cfg_alarm: assert property (@(posedge clock_i) disable iff (reset_i) // R3
		state == hsc_pkg::HSC_POWERUP && cfg_taken |=> leds_o.alarm == $past(cfg_changed))
		else $error("power-up alarm light does not follow configuration change");
	chk_link_light: assert property (@(posedge clock_i) disable iff (reset_i) // R4
		link_active_i |=> leds_o.link)
		else $error("link light missing while link active");
	chk_cal_run: assert property (@(posedge clock_i) disable iff (reset_i) // R5
		cal_start |=> state == hsc_pkg::HSC_CAL ##1 leds_o.cal [*8])
		else $error("calibration run did not start with light on");
	chk_cal_zero_out: assert property (@(posedge clock_i) disable iff (reset_i) // R6
		state == hsc_pkg::HSC_CAL |=> actual_dac_o == hsc_pkg::DAC_ZERO)
		else $error("analog output not zero during calibration");
	chk_cal_pass_code: assert property (@(posedge clock_i) disable iff (reset_i) // R7
		cal_end && zero_ok_i && !range_500_i ##1 state == hsc_pkg::HSC_IDLE && !range_500_i
		&& !ctrl[hsc_pkg::CTRL_START_HEAT] |=> actual_dac_o == hsc_pkg::DAC_CAL_300)
		else $error("range code missing after good calibration");
	chk_cal_fail_alarm: assert property (@(posedge clock_i) disable iff (reset_i) // R8
		cal_end && !zero_ok_i |=> alarm_active)
		else $error("alarm bit not raised on failed calibration");
	chk_heat_start: assert property (@(posedge clock_i) disable iff (reset_i) // R9
		state == hsc_pkg::HSC_IDLE && !cal_start && ctrl[hsc_pkg::CTRL_START_HEAT]
		&& ctrl[hsc_pkg::CTRL_HEAT_EN] |=> state == hsc_pkg::HSC_HEAT ##1 leds_o.heat)
		else $error("heating did not start on start bit");
	chk_no_heat_cal: assert property (@(posedge clock_i) disable iff (reset_i) // R17
		state == hsc_pkg::HSC_CAL |=> !heat_on_o)
		else $error("heater on during calibration");
	chk_line_window: assert property (@(posedge clock_i) disable iff (reset_i) // R14
		line_edge && line_cnt + 32'h1 > 32'(LINE_MAX_CYC) |=> !line_ok)
		else $error("line accepted below the frequency window");
	chk_cal_disabled: assert property (@(posedge clock_i) disable iff (reset_i) // R15
		ctrl[hsc_pkg::CTRL_CAL_REQ] && !ctrl[hsc_pkg::CTRL_CAL_EN] |-> !cal_start)
		else $error("calibration ran while disabled");
	chk_wb_ack: assert property (@(posedge clock_i) disable iff (reset_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle after request");

	cov_cal_pass: cover property (@(posedge clock_i) disable iff (reset_i)
		cal_end && zero_ok_i);
	cov_cal_fail: cover property (@(posedge clock_i) disable iff (reset_i)
		cal_end && !zero_ok_i);
	cov_heat: cover property (@(posedge clock_i) disable iff (reset_i)
		state == hsc_pkg::HSC_HEAT && cal_good);
	cov_irq: cover property (@(posedge clock_i) disable iff (reset_i) irq_o);

endmodule

// ==== dv/hsc_plant_model.sv ====
// far side model: fieldbus link activity, line sync wave and zero calibration result
`timescale 1ns/1ns
module hsc_plant_model #(
	parameter int LINE_CYC = 50
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// scenario controls
	input wire logic link_en_i,
	input wire logic zero_good_i,
	input wire logic line_hold_i,
	// toward the sequencer
	output logic link_active_o,
	output logic line_sync_o,
	output logic zero_ok_o
);
	int phase;
	// line wave half high and half low; holding it stages a lost line
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			phase <= 0;
		end else if (!line_hold_i) begin
			phase <= (phase == LINE_CYC - 1) ? 0 : phase + 1;
		end
	end
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			line_sync_o <= 1'b0;
			link_active_o <= 1'b0;
			zero_ok_o <= 1'b0;
		end else begin
			line_sync_o <= (phase < LINE_CYC / 2);
			link_active_o <= link_en_i;
			zero_ok_o <= zero_good_i;
		end
	end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the heater startup and calibration sequencer
`timescale 1ns/1ns
module tb_top;
	// --------------------------------------------------------------------
	// signals
	// --------------------------------------------------------------------
	logic clock_i, reset_i, cyc, stb, we, ack, link_en, good, cfg, rng, link, sync, zok, heat, irq;
	logic hold;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [11:0] act, dac;
	hsc_pkg::hsc_led_s leds;
	int mismatches, tests_run, ones;

	hsc_sequencer #(.POWERUP_CYC(20), .SLOW_HALF_CYC(8), .FAST_HALF_CYC(2), .CAL_RUN_CYC(50),
		.LINE_MIN_CYC(40), .LINE_MAX_CYC(60)) dut (
		.clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.link_active_i(link), .config_changed_i(cfg), .line_sync_i(sync), .zero_ok_i(zok),
		.range_500_i(rng), .actual_value_i(act), .leds_o(leds), .heat_on_o(heat),
		.actual_dac_o(dac), .irq_o(irq));
	hsc_plant_model plant (.clock_i(clock_i), .reset_i(reset_i),
		.link_en_i(link_en), .zero_good_i(good), .line_hold_i(hold), .link_active_o(link),
		.line_sync_o(sync), .zero_ok_o(zok));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// --------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------
	task automatic end_of_test();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		tests_run++;
		if (!ok) begin
			mismatches++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// request held until ack is seen high at a rising edge; data taken and request dropped there
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s = 4'hf);
		int n;
		@(posedge clock_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(0, "bus timeout");
			end_of_test();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic watch(input int idx, input int n);
		logic [3:0] lv;
		ones = 0;
		repeat (n) begin
			@(negedge clock_i);
			lv = leds;
			ones += int'(lv[idx] === 1'b1);
		end
	endtask
	task automatic wait_cal();
		int n;
		n = 0;
		do begin
			wb(0, hsc_pkg::ADDR_STATUS, 0);
			n++;
		end while (q[hsc_pkg::STAT_CAL_ACTIVE] !== 1'b0 && n < 60);
		chk(n < 60, "calibration never ended");
	endtask

	// --------------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------------
	task automatic t_powerup();
		repeat (3) @(negedge clock_i);
		chk(leds.cal === 1'b1, "no power-up light");
		chk(leds.alarm === 1'b1, "no altered-config light");
		repeat (25) @(negedge clock_i);
		chk(leds.alarm === 1'b0, "alarm light stays");
		watch(3, 20);
		chk(ones > 0 && ones < 20, "no slow blink without link");
		@(posedge clock_i);
		link_en <= 1'b1;
		repeat (4) @(negedge clock_i);
		chk(leds.link === 1'b1, "link light off");
		watch(3, 20);
		chk(ones == 0, "blink goes on with link");
	endtask
	task automatic t_regs();
		wb(0, hsc_pkg::ADDR_CTRL, 0);
		chk(q === 32'h0000000c, "control reset value");
		wb(0, 8'h20, 0);
		chk(q === 32'h00000000, "unmapped read");
		wb(0, hsc_pkg::ADDR_LINE_PERIOD, 0);
		chk(q === 32'h00000032, "line period");
		wb(0, hsc_pkg::ADDR_STATUS, 0);
		chk(q === 32'h00000018, "status after start");
		@(negedge clock_i);
		chk(dac === 12'h3a5, "output does not follow actual before calibration");
	endtask
	task automatic t_cal_ok();
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000d);
		repeat (3) @(negedge clock_i);
		chk(leds.cal === 1'b1 && dac === hsc_pkg::DAC_ZERO, "run light or zero out");
		wb(0, hsc_pkg::ADDR_STATUS, 0);
		chk(q[hsc_pkg::STAT_CAL_ACTIVE] === 1'b1, "active bit");
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000f);
		repeat (3) @(negedge clock_i);
		chk(heat === 1'b0 && leds.heat === 1'b0, "heating during run");
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000d);
		wait_cal();
		repeat (2) @(negedge clock_i);
		chk(leds.cal === 1'b0 && dac === hsc_pkg::DAC_CAL_300, "300 range result");
		chk(irq === 1'b0, "masked interrupt");
		wb(1, hsc_pkg::ADDR_IRQ_MASK, 32'h1 << hsc_pkg::IRQ_CAL_DONE);
		repeat (2) @(negedge clock_i);
		chk(irq === 1'b1, "done interrupt");
		wb(1, hsc_pkg::ADDR_IRQ_STAT, 32'h1 << hsc_pkg::IRQ_CAL_DONE);
		repeat (2) @(negedge clock_i);
		chk(irq === 1'b0, "interrupt clear");
	endtask
	task automatic t_cal_fail();
		@(posedge clock_i);
		good <= 1'b0;
		rng <= 1'b1;
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000c);
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000d);
		wait_cal();
		chk(q[hsc_pkg::STAT_ALARM_ACTIVE] === 1'b1, "alarm bit");
		watch(2, 20);
		chk(ones > 0 && ones < 20, "alarm slow blink");
		wb(0, hsc_pkg::ADDR_IRQ_STAT, 0);
		chk(q[hsc_pkg::IRQ_CAL_FAIL] === 1'b1, "fail event");
		@(posedge clock_i);
		good <= 1'b1;
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000c);
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000d);
		wait_cal();
		chk(q[hsc_pkg::STAT_ALARM_ACTIVE] === 1'b0, "alarm bit stays");
		repeat (2) @(negedge clock_i);
		chk(dac === hsc_pkg::DAC_CAL_500, "500 range result");
	endtask
	task automatic t_heat();
		wb(1, hsc_pkg::ADDR_SETPOINT, 32'h00001234);
		wb(1, hsc_pkg::ADDR_SETPOINT, 32'h0000ab99, 4'h1);
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000e);
		repeat (3) @(negedge clock_i);
		chk(heat === 1'b1 && leds.heat === 1'b1, "heat not on");
		@(posedge clock_i);
		act <= 12'h5a1;
		repeat (2) @(negedge clock_i);
		chk(dac === 12'h5a1, "output does not follow actual while heating");
		wb(0, hsc_pkg::ADDR_STATUS, 0);
		chk(q[hsc_pkg::STAT_CTRL_ACTIVE] === 1'b1, "controller bit");
		wb(0, hsc_pkg::ADDR_CTRL, 0);
		chk(q === 32'h1299000e, "control readback with byte enables");
		wb(1, hsc_pkg::ADDR_CTRL, 32'h0000000c);
		repeat (3) @(negedge clock_i);
		chk(heat === 1'b0, "heat not off");
	endtask
	task automatic t_disabled();
		wb(1, hsc_pkg::ADDR_CTRL, 32'h00000003);
		watch(3, 6);
		chk(ones > 0 && ones < 6, "no fast calibration blink");
		watch(1, 12);
		chk(ones > 0 && ones < 12 && heat === 1'b0, "no fast heat blink");
		wb(0, hsc_pkg::ADDR_STATUS, 0);
		chk(q[hsc_pkg::STAT_CAL_ACTIVE] === 1'b0, "disabled run started");
	endtask
	task automatic t_line();
		@(posedge clock_i);
		hold <= 1'b1;
		repeat (70) @(negedge clock_i);
		wb(0, hsc_pkg::ADDR_STATUS, 0);
		chk(q[hsc_pkg::STAT_LINE_OK] === 1'b0, "lost line still accepted");
		wb(0, hsc_pkg::ADDR_IRQ_STAT, 0);
		chk(q[hsc_pkg::IRQ_LINE_LOST] === 1'b1, "no line lost event");
		@(posedge clock_i);
		hold <= 1'b0;
		repeat (120) @(negedge clock_i);
		wb(0, hsc_pkg::ADDR_STATUS, 0);
		chk(q[hsc_pkg::STAT_LINE_OK] === 1'b1, "line not regained");
	endtask
	task automatic t_reset();
		@(posedge clock_i);
		cfg <= 1'b0;
		reset_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		reset_i <= 1'b0;
		repeat (3) @(negedge clock_i);
		chk(leds.cal === 1'b1, "no power-up light after reset");
		chk(leds.alarm === 1'b0, "alarm light without altered config");
		wb(0, hsc_pkg::ADDR_STATUS, 0);
		chk(q === 32'h00000000, "status after second reset");
	endtask

	// --------------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------------
	initial begin
		mismatches = 0;
		tests_run = 0;
		reset_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		link_en = 1'b0;
		hold = 1'b0;
		good = 1'b1;
		cfg = 1'b1;
		rng = 1'b0;
		act = 12'h3a5;
		repeat (5) @(posedge clock_i);
		reset_i <= 1'b0;
		t_powerup();
		t_regs();
		t_cal_ok();
		t_cal_fail();
		t_heat();
		t_disabled();
		t_line();
		t_reset();
		end_of_test();
	end
	initial begin
		#500000;
		chk(0, "run timeout");
		end_of_test();
	end
endmodule
